//--- bus_ext_pkg.sv
// Constants shared by the cable-bus status/control and lock register logic.
// Assumes a 50 MHz system clock and a 16-bit register port with byte offsets.
`default_nettype none

package bus_ext_pkg;

	// ----------------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------------
	localparam logic [7:0] STATUS_CONTROL_OFFSET = 8'h20;
	localparam logic [7:0] CROSS_BUS_LOCK_OFFSET = 8'h22;

	// ----------------------------------------------------------------------
	// Status/control field positions (read and write views share numbers)
	// ----------------------------------------------------------------------
	localparam int CTRL_TIMEOUT_BIT = 11;
	localparam int ECL0_ENABLE_BIT = 11;
	localparam int INTERLOCK_BIT = 10;
	localparam int ECL0_DIRECTION_BIT = 10;
	localparam int SYSFAIL_DRIVE_BIT = 9;
	localparam int FAIR_BIT = 8;
	localparam int SYSRESET_PULSE_BIT = 8;
	localparam int CONTROLLER_BIT = 7;
	localparam int TRIGGER_BIT = 6;
	localparam int SYSRESET_BIT = 5;
	localparam int ACFAIL_BIT = 4;
	localparam int EXT_TIMEOUT_BIT = 3;
	localparam int BUS_ERROR_BIT = 2;
	localparam int DEADLOCK_CLEAR_BIT = 2;
	localparam int SYSFAIL_BIT = 1;
	localparam int PARITY_BIT = 0;
	localparam int LOCK_BIT = 0;

	// Reserved bits that read back as ones
	localparam logic [15:0] STATUS_RESERVED_ONES = 16'h3000;
	localparam logic [15:0] LOCK_RESERVED_ONES = 16'hfffe;

	// ----------------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------------
	localparam logic [15:0] READ_DATA_RESET = 16'h0000;
	localparam int CLOCK_PERIOD_NS = 20;
	localparam longint SYSRESET_PULSE_NS = 200_000_000;
	localparam longint SHORT_TIMEOUT_MIN_NS = 100_000;
	localparam longint SHORT_TIMEOUT_MAX_NS = 400_000;
	localparam longint LONG_TIMEOUT_MIN_NS = 100_000_000;
	localparam longint LONG_TIMEOUT_MAX_NS = 400_000_000;
	// Least times round up to whole cycles
	localparam int SYSRESET_PULSE_CYCLES = int'((SYSRESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam int SHORT_TIMEOUT_MIN_CYCLES = int'((SHORT_TIMEOUT_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam int SHORT_TIMEOUT_MAX_CYCLES = int'(SHORT_TIMEOUT_MAX_NS / CLOCK_PERIOD_NS);
	localparam int LONG_TIMEOUT_MIN_CYCLES = int'((LONG_TIMEOUT_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam int LONG_TIMEOUT_MAX_CYCLES = int'(LONG_TIMEOUT_MAX_NS / CLOCK_PERIOD_NS);
	localparam int COUNT_WIDTH = 25;

endpackage : bus_ext_pkg

`default_nettype wire

//--- bus_extender_status_lock_regs.sv
// Status/control and cross-bus lock registers of a mainframe extender cable-bus interface.
// Assumes one 50 MHz clock, synchronous inputs and a simple read/write register port that
// also tells which side (local backplane or cable link) made the access.
`timescale 1ns/1ps
`default_nettype none

module bus_extender_status_lock_regs #(
	parameter int SYSRESET_PULSE_CYCLES = bus_ext_pkg::SYSRESET_PULSE_CYCLES,
	parameter int SHORT_TIMEOUT_MIN_CYCLES = bus_ext_pkg::SHORT_TIMEOUT_MIN_CYCLES,
	parameter int SHORT_TIMEOUT_MAX_CYCLES = bus_ext_pkg::SHORT_TIMEOUT_MAX_CYCLES,
	parameter int LONG_TIMEOUT_MIN_CYCLES = bus_ext_pkg::LONG_TIMEOUT_MIN_CYCLES,
	parameter int LONG_TIMEOUT_MAX_CYCLES = bus_ext_pkg::LONG_TIMEOUT_MAX_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_from_link,
	output logic [15:0] reg_rdata,
	// Board switches and timeout jumper
	input wire logic interlock_switch,
	input wire logic fair_switch,
	input wire logic controller_switch,
	input wire logic timeout_jumper_long,
	// Link transfer events
	input wire logic link_cycle_active,
	input wire logic link_xfer_done,
	input wire logic link_xfer_berr,
	input wire logic link_xfer_parity,
	output logic controller_timeout_berr,
	// Backplane event lines
	input wire logic trigger_interrupt,
	input wire logic sysreset_active,
	input wire logic acfail_active,
	input wire logic sysfail_active,
	input wire logic sysfail_to_link_enable,
	output logic link_irq_out,
	output logic sysfail_out,
	output logic sysreset_out,
	output logic deadlock_flag_clear,
	// Trigger line 0 and front panel
	input wire logic ecl_line0_in,
	output logic ecl_line0_out,
	output logic ecl_line0_oe_n,
	input wire logic front_panel_trigger_input,
	output logic front_panel_trigger_output,
	// Cross-bus lock
	input wire logic link_won,
	output logic link_lock_hold,
	output logic local_bus_lock
);

	// ----------------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------------
	logic sc_wr;
	logic sc_rd;
	logic lock_wr;
	logic lock_rd;
	logic soft_clr;

	assign sc_wr = reg_wr && (reg_addr == bus_ext_pkg::STATUS_CONTROL_OFFSET);
	assign sc_rd = reg_rd && (reg_addr == bus_ext_pkg::STATUS_CONTROL_OFFSET);
	assign lock_wr = reg_wr && (reg_addr == bus_ext_pkg::CROSS_BUS_LOCK_OFFSET);
	assign lock_rd = reg_rd && (reg_addr == bus_ext_pkg::CROSS_BUS_LOCK_OFFSET);
	assign soft_clr = soft_reset;

	// ----------------------------------------------------------------------
	// Switch status
	// ----------------------------------------------------------------------
	logic interlocked_mode_status_r;
	logic fair_status_r;
	logic link_controller_status_r;

	// Switches are sampled every cycle and never reset, so resets cannot disturb them
	always_ff @(posedge clk) begin
		interlocked_mode_status_r <= interlock_switch;
		fair_status_r <= fair_switch;
		link_controller_status_r <= controller_switch;
	end

	// ----------------------------------------------------------------------
	// Hard-reset-only control bits
	// ----------------------------------------------------------------------
	logic ecl_line0_route_enable_r;
	logic ecl_line0_route_direction_r;
	logic trigger_event_to_link_enable_r;
	logic sysreset_to_link_enable_r;
	logic acfail_to_link_enable_r;
	logic extended_timeout_select_r;

	// Routing and timeout choice survive a soft reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ecl_line0_route_enable_r <= 1'b0;
			ecl_line0_route_direction_r <= 1'b0;
			trigger_event_to_link_enable_r <= 1'b0;
			sysreset_to_link_enable_r <= 1'b0;
			acfail_to_link_enable_r <= 1'b0;
			extended_timeout_select_r <= 1'b0;
		end else if (sc_wr) begin
			ecl_line0_route_enable_r <= reg_wdata[bus_ext_pkg::ECL0_ENABLE_BIT];
			ecl_line0_route_direction_r <= reg_wdata[bus_ext_pkg::ECL0_DIRECTION_BIT];
			trigger_event_to_link_enable_r <= reg_wdata[bus_ext_pkg::TRIGGER_BIT];
			sysreset_to_link_enable_r <= reg_wdata[bus_ext_pkg::SYSRESET_BIT];
			acfail_to_link_enable_r <= reg_wdata[bus_ext_pkg::ACFAIL_BIT];
			extended_timeout_select_r <= reg_wdata[bus_ext_pkg::EXT_TIMEOUT_BIT];
		end
	end

	// ----------------------------------------------------------------------
	// SYSFAIL drive
	// ----------------------------------------------------------------------
	logic sysfail_drive_r;

	always_ff @(posedge clk) begin
		if (!rst_n || soft_clr) begin
			sysfail_drive_r <= 1'b0;
		end else if (sc_wr) begin
			sysfail_drive_r <= reg_wdata[bus_ext_pkg::SYSFAIL_DRIVE_BIT];
		end
	end

	// The pin follows the bit one cycle later
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sysfail_out <= 1'b0;
		end else begin
			sysfail_out <= sysfail_drive_r;
		end
	end

	// ----------------------------------------------------------------------
	// SYSRESET pulse
	// ----------------------------------------------------------------------
	logic sysreset_pulse_request_r;
	logic [bus_ext_pkg::COUNT_WIDTH-1:0] pulse_count_r;

	// A soft reset does not cut the pulse short, since the pulse is itself a reset of the crate
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sysreset_pulse_request_r <= 1'b0;
			pulse_count_r <= '0;
		end else if (sysreset_pulse_request_r) begin
			if (pulse_count_r == bus_ext_pkg::COUNT_WIDTH'(SYSRESET_PULSE_CYCLES - 1)) begin
				sysreset_pulse_request_r <= 1'b0;
				pulse_count_r <= '0;
			end else begin
				pulse_count_r <= pulse_count_r + 1'b1;
			end
		end else if (sc_wr && reg_wdata[bus_ext_pkg::SYSRESET_PULSE_BIT]) begin
			sysreset_pulse_request_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sysreset_out <= 1'b0;
		end else begin
			sysreset_out <= sysreset_pulse_request_r;
		end
	end

	// ----------------------------------------------------------------------
	// Controller timeout timer
	// ----------------------------------------------------------------------
	logic [bus_ext_pkg::COUNT_WIDTH-1:0] timeout_count_r;
	logic [bus_ext_pkg::COUNT_WIDTH-1:0] timeout_limit;
	logic timeout_hit;

	// Jumper picks the low or high end of each documented range
	always_comb begin
		if (extended_timeout_select_r) begin
			timeout_limit = timeout_jumper_long ? bus_ext_pkg::COUNT_WIDTH'(LONG_TIMEOUT_MAX_CYCLES)
				: bus_ext_pkg::COUNT_WIDTH'(LONG_TIMEOUT_MIN_CYCLES);
		end else begin
			timeout_limit = timeout_jumper_long ? bus_ext_pkg::COUNT_WIDTH'(SHORT_TIMEOUT_MAX_CYCLES)
				: bus_ext_pkg::COUNT_WIDTH'(SHORT_TIMEOUT_MIN_CYCLES);
		end
	end

	assign timeout_hit = link_controller_status_r && link_cycle_active && (timeout_count_r == timeout_limit - 1'b1);

	// Counter restarts whenever the link goes idle, so each cycle gets the full window
	always_ff @(posedge clk) begin
		if (!rst_n || !link_cycle_active || !link_controller_status_r) begin
			timeout_count_r <= '0;
		end else if (timeout_count_r != timeout_limit) begin
			timeout_count_r <= timeout_count_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			controller_timeout_berr <= 1'b0;
		end else begin
			controller_timeout_berr <= timeout_hit;
		end
	end

	// ----------------------------------------------------------------------
	// Transfer outcome flags
	// ----------------------------------------------------------------------
	logic controller_timeout_flag_r;
	logic link_bus_error_flag_r;
	logic link_parity_fault_r;

	// A timeout arriving with the clearing read still sets the flag
	always_ff @(posedge clk) begin
		if (!rst_n || soft_clr) begin
			controller_timeout_flag_r <= 1'b0;
		end else if (controller_timeout_berr && link_controller_status_r) begin
			controller_timeout_flag_r <= 1'b1;
		end else if (sc_rd) begin
			controller_timeout_flag_r <= 1'b0;
		end
	end

	// Both flags describe only the most recent transfer
	always_ff @(posedge clk) begin
		if (!rst_n || soft_clr) begin
			link_bus_error_flag_r <= 1'b0;
			link_parity_fault_r <= 1'b0;
		end else if (link_xfer_done) begin
			link_bus_error_flag_r <= link_xfer_berr;
			link_parity_fault_r <= link_xfer_parity;
		end
	end

	// Deadlock clear is a one-cycle strobe to the interrupt status logic
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			deadlock_flag_clear <= 1'b0;
		end else begin
			deadlock_flag_clear <= sc_wr && reg_wdata[bus_ext_pkg::DEADLOCK_CLEAR_BIT];
		end
	end

	// ----------------------------------------------------------------------
	// Link interrupt mapping
	// ----------------------------------------------------------------------
	logic trigger_event_on_link_status_r;
	logic sysreset_on_link_status_r;
	logic acfail_on_link_status_r;
	logic sysfail_on_link_status_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trigger_event_on_link_status_r <= 1'b0;
			sysreset_on_link_status_r <= 1'b0;
			acfail_on_link_status_r <= 1'b0;
			sysfail_on_link_status_r <= 1'b0;
		end else begin
			trigger_event_on_link_status_r <= trigger_interrupt && trigger_event_to_link_enable_r;
			sysreset_on_link_status_r <= sysreset_active && sysreset_to_link_enable_r;
			acfail_on_link_status_r <= acfail_active && acfail_to_link_enable_r;
			sysfail_on_link_status_r <= sysfail_active && sysfail_to_link_enable;
		end
	end

	// One wired line on the link, so the sources simply OR together
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link_irq_out <= 1'b0;
		end else begin
			link_irq_out <= (trigger_interrupt && trigger_event_to_link_enable_r)
				|| (sysreset_active && sysreset_to_link_enable_r)
				|| (acfail_active && acfail_to_link_enable_r)
				|| (sysfail_active && sysfail_to_link_enable);
		end
	end

	// ----------------------------------------------------------------------
	// Trigger line 0 routing
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			front_panel_trigger_output <= 1'b0;
			ecl_line0_out <= 1'b0;
			ecl_line0_oe_n <= 1'b1;
		end else begin
			front_panel_trigger_output <= ecl_line0_route_enable_r && !ecl_line0_route_direction_r
				&& ecl_line0_in;
			ecl_line0_out <= front_panel_trigger_input;
			ecl_line0_oe_n <= !(ecl_line0_route_enable_r && ecl_line0_route_direction_r);
		end
	end

	// ----------------------------------------------------------------------
	// Cross-bus lock
	// ----------------------------------------------------------------------
	logic link_lock_request_r;
	logic local_lock_r;
	logic link_locked_r;

	// Whichever side writes the lock bit decides which bus gets locked
	always_ff @(posedge clk) begin
		if (!rst_n || soft_clr) begin
			link_lock_request_r <= 1'b0;
			local_lock_r <= 1'b0;
		end else if (lock_wr) begin
			if (reg_from_link) begin
				local_lock_r <= reg_wdata[bus_ext_pkg::LOCK_BIT];
			end else begin
				link_lock_request_r <= reg_wdata[bus_ext_pkg::LOCK_BIT];
			end
		end
	end

	// The link only counts as locked once this unit owns it
	always_ff @(posedge clk) begin
		if (!rst_n || soft_clr) begin
			link_locked_r <= 1'b0;
		end else if (!link_lock_request_r) begin
			link_locked_r <= 1'b0;
		end else if (link_won) begin
			link_locked_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link_lock_hold <= 1'b0;
			local_bus_lock <= 1'b0;
		end else begin
			link_lock_hold <= link_locked_r;
			local_bus_lock <= local_lock_r;
		end
	end

	// ----------------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------------
	logic [15:0] status_word;
	logic [15:0] lock_word;

	always_comb begin
		status_word = bus_ext_pkg::STATUS_RESERVED_ONES;
		status_word[bus_ext_pkg::CTRL_TIMEOUT_BIT] = controller_timeout_flag_r;
		status_word[bus_ext_pkg::INTERLOCK_BIT] = interlocked_mode_status_r;
		status_word[bus_ext_pkg::SYSFAIL_DRIVE_BIT] = sysfail_drive_r;
		status_word[bus_ext_pkg::FAIR_BIT] = fair_status_r;
		status_word[bus_ext_pkg::CONTROLLER_BIT] = link_controller_status_r;
		status_word[bus_ext_pkg::TRIGGER_BIT] = trigger_event_on_link_status_r;
		status_word[bus_ext_pkg::SYSRESET_BIT] = sysreset_on_link_status_r;
		status_word[bus_ext_pkg::ACFAIL_BIT] = acfail_on_link_status_r;
		status_word[bus_ext_pkg::EXT_TIMEOUT_BIT] = extended_timeout_select_r;
		status_word[bus_ext_pkg::BUS_ERROR_BIT] = link_bus_error_flag_r;
		status_word[bus_ext_pkg::SYSFAIL_BIT] = sysfail_on_link_status_r;
		status_word[bus_ext_pkg::PARITY_BIT] = link_parity_fault_r;
	end

	// Each side sees the state of the bus on the far side of the extender
	always_comb begin
		lock_word = bus_ext_pkg::LOCK_RESERVED_ONES;
		lock_word[bus_ext_pkg::LOCK_BIT] = reg_from_link ? local_lock_r : link_locked_r;
	end

	// Read data is registered and holds until the next read; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= bus_ext_pkg::READ_DATA_RESET;
		end else if (sc_rd) begin
			reg_rdata <= status_word;
		end else if (lock_rd) begin
			reg_rdata <= lock_word;
		end else if (reg_rd) begin
			reg_rdata <= bus_ext_pkg::READ_DATA_RESET;
		end
	end

endmodule : bus_extender_status_lock_regs

`default_nettype wire

//--- link_partner.sv
// Far-side model: a remote link master running one transfer per go pulse.
// Assumes commands on rising edges; qualifiers change every cycle when idle.
`timescale 1ns/1ps
`default_nettype none

module link_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic hold,
	input wire logic [3:0] dly,
	input wire logic berr,
	input wire logic par,
	output logic active,
	output logic done,
	output logic done_berr,
	output logic done_par
);
	logic [3:0] cnt_r;
	logic tgl_r;
	// A held transfer models a dead slave, so only releasing hold or a reset can end it
	always_ff @(posedge clk) begin
		done <= 1'b0;
		tgl_r <= !tgl_r;
		if (!rst_n) begin
			active <= 1'b0;
			tgl_r <= 1'b0;
		end else if (go && !active) begin
			active <= 1'b1;
			cnt_r <= dly;
		end else if (active && (hold || cnt_r != 4'h0)) begin
			cnt_r <= cnt_r - {3'h0, !hold};
		end else if (active) begin
			active <= 1'b0;
			done <= 1'b1;
		end
	end
	// Qualifiers mean nothing outside done, so they must not look stable
	assign done_berr = done ? berr : tgl_r;
	assign done_par = done ? par : !tgl_r;
endmodule : link_partner

`default_nettype wire

//--- status_lock_properties.sv
// Port-level checker for the status/control and cross-bus lock block.
// Assumes one clock and synchronous active-low reset; bound in below.
`timescale 1ns/1ps
`default_nettype none

module status_lock_properties #(
	parameter int SYSRESET_PULSE_CYCLES = 20,
	parameter int SHORT_TIMEOUT_MIN_CYCLES = 10,
	parameter int LONG_TIMEOUT_MAX_CYCLES = 80
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_from_link,
	input wire logic [15:0] reg_rdata,
	input wire logic link_cycle_active,
	input wire logic controller_timeout_berr,
	input wire logic link_won,
	input wire logic sysfail_out,
	input wire logic sysreset_out,
	input wire logic deadlock_flag_clear,
	input wire logic ecl_line0_out,
	input wire logic ecl_line0_oe_n,
	input wire logic front_panel_trigger_input,
	input wire logic link_lock_hold,
	input wire logic local_bus_lock
);
	// ----
	// Helper logic
	// ----
	logic [7:0] pulse_r;
	logic [7:0] wait_r;
	wire sc_wr = reg_wr && reg_addr == bus_ext_pkg::STATUS_CONTROL_OFFSET;
	wire lk_wr = reg_wr && reg_addr == bus_ext_pkg::CROSS_BUS_LOCK_OFFSET;
	wire pulse_wr = sc_wr && reg_wdata[bus_ext_pkg::SYSRESET_PULSE_BIT];
	wire lk_set = lk_wr && reg_from_link && reg_wdata[bus_ext_pkg::LOCK_BIT];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Counters stand in for long repetitions, which the tools unroll badly
	always_ff @(posedge clk) begin
		pulse_r <= (!rst_n || !sysreset_out) ? 8'h00 : pulse_r + 8'h01;
		wait_r <= (!rst_n || !link_cycle_active) ? 8'h00 : wait_r + 8'h01;
	end
	// ----
	// Assertions
	// ----
	reset_outputs_a: assert property (disable iff (1'b0) !rst_n |=> ecl_line0_oe_n && !link_lock_hold
		&& !local_bus_lock && !sysreset_out && reg_rdata == 16'h0000) else $error("outputs not reset");
	pulse_length_a: assert property ($fell(sysreset_out) && $past(rst_n) |-> pulse_r >= SYSRESET_PULSE_CYCLES)
		else $error("reset pulse too short");
	pulse_cause_a: assert property ($rose(sysreset_out) |-> $past(pulse_wr, 2))
		else $error("reset pulse without write");
	soft_clear_a: assert property (soft_reset && !reg_wr |-> ##2 !sysfail_out && !link_lock_hold && !local_bus_lock)
		else $error("soft reset left drive or lock");
	flag_pulse_a: assert property (sc_wr && reg_wdata[2] |=> deadlock_flag_clear)
		else $error("no deadlock clear pulse");
	lock_read_a: assert property (reg_rd && reg_addr == bus_ext_pkg::CROSS_BUS_LOCK_OFFSET |=> reg_rdata[15:1] == 15'h7fff)
		else $error("lock reserved bits not ones");
	route_in_a: assert property (!ecl_line0_oe_n |-> ecl_line0_out == $past(front_panel_trigger_input))
		else $error("trigger line not from front input");
	timeout_range_a: assert property (controller_timeout_berr |-> wait_r >= SHORT_TIMEOUT_MIN_CYCLES
		&& wait_r <= LONG_TIMEOUT_MAX_CYCLES + 6) else $error("timeout out of range");
	hold_cause_a: assert property ($rose(link_lock_hold) |-> $past(link_won, 2))
		else $error("link held before it was won");
	local_cause_a: assert property ($rose(local_bus_lock) |-> $past(lk_set, 2))
		else $error("local lock without link write");
	pulse_c: cover property ($rose(sysreset_out));
	hold_c: cover property ($rose(link_lock_hold));
	timeout_c: cover property (controller_timeout_berr);
endmodule : status_lock_properties

bind bus_extender_status_lock_regs status_lock_properties #(.SYSRESET_PULSE_CYCLES(SYSRESET_PULSE_CYCLES),
	.SHORT_TIMEOUT_MIN_CYCLES(SHORT_TIMEOUT_MIN_CYCLES), .LONG_TIMEOUT_MAX_CYCLES(LONG_TIMEOUT_MAX_CYCLES)) i_props (.*);

`default_nettype wire

//--- tb.sv
// Self-checking bench for the status/control and cross-bus lock block.
// Assumes the link partner model and the bound checker compile beside it.
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam logic [7:0] SC = bus_ext_pkg::STATUS_CONTROL_OFFSET;
	localparam logic [7:0] LK = bus_ext_pkg::CROSS_BUS_LOCK_OFFSET;
	localparam int PULSE = 20;
	typedef struct packed {logic [15:0] wd; logic [2:0] sw; logic [4:0] src; logic [15:0] exp; logic irq; logic sf;} row_type;
	// Switches {interlock, fair, controller}; sources {trig, sysreset, acfail, sysfail, sysfail enable}
	row_type rows [6] = '{'{16'h0000, 3'h0, 5'h1f, 16'h3002, 1'b1, 1'b0}, '{16'h0070, 3'h5, 5'h10, 16'h34c0, 1'b1, 1'b0},
		'{16'h0030, 3'h2, 5'h0c, 16'h3130, 1'b1, 1'b0}, '{16'h0208, 3'h0, 5'h1e, 16'h3208, 1'b0, 1'b1},
		'{16'h0040, 3'h0, 5'h0f, 16'h3002, 1'b1, 1'b0}, '{16'h0000, 3'h0, 5'h00, 16'h3000, 1'b0, 1'b0}};
	logic [6:0] xf [4] = '{7'h33, 7'h00, 7'h1f, 7'h61}; // {soft reset, berr, parity, delay}
	logic clk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_from_link = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic interlock_switch = 1'b0, fair_switch = 1'b0, controller_switch = 1'b0, timeout_jumper_long = 1'b0;
	logic trigger_interrupt = 1'b0, sysreset_active = 1'b0, acfail_active = 1'b0, sysfail_active = 1'b0;
	logic sysfail_to_link_enable = 1'b0, ecl_line0_in = 1'b0, front_panel_trigger_input = 1'b0, link_won = 1'b0;
	logic link_cycle_active, link_xfer_done, link_xfer_berr, link_xfer_parity, controller_timeout_berr;
	logic link_irq_out, sysfail_out, sysreset_out, deadlock_flag_clear, ecl_line0_out, ecl_line0_oe_n;
	logic front_panel_trigger_output, link_lock_hold, local_bus_lock;
	logic p_go = 1'b0, p_hold = 1'b0, p_berr = 1'b0, p_par = 1'b0;
	logic [3:0] p_dly = 4'h0;
	int miscompares = 0, num_checks = 0, n, lim;

	// Short counts keep the pulse and timeout tests within a few hundred cycles
	bus_extender_status_lock_regs #(.SYSRESET_PULSE_CYCLES(PULSE), .SHORT_TIMEOUT_MIN_CYCLES(10),
		.SHORT_TIMEOUT_MAX_CYCLES(20), .LONG_TIMEOUT_MIN_CYCLES(40), .LONG_TIMEOUT_MAX_CYCLES(80)) i_dut (.*);
	link_partner i_link (.clk(clk), .rst_n(rst_n), .go(p_go), .hold(p_hold), .dly(p_dly), .berr(p_berr), .par(p_par),
		.active(link_cycle_active), .done(link_xfer_done), .done_berr(link_xfer_berr), .done_par(link_xfer_parity));

	initial forever #10 clk = ~clk;

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t: word %h, expected %h", $time, got, exp);
		end
	endtask : chk16
	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	// One strobe cycle; returns mid-cycle once the read data has landed
	task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic lnk);
		@(posedge clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata, reg_from_link} <= {wr, !wr, a, d, lnk};
		@(posedge clk);
		{reg_wr, reg_rd} <= 2'b00;
		@(negedge clk);
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic lnk, input logic [15:0] exp);
		acc(1'b0, a, 16'h0000, lnk);
		chk16(reg_rdata, exp);
	endtask : rd
	task automatic final_report();
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk);
			{interlock_switch, fair_switch, controller_switch} <= rows[i].sw;
			{trigger_interrupt, sysreset_active, acfail_active, sysfail_active, sysfail_to_link_enable} <= rows[i].src;
			acc(1'b1, SC, rows[i].wd, 1'b0);
			cyc(2);
			rd(SC, 1'b0, rows[i].exp);
			chk1(link_irq_out, rows[i].irq);
			chk1(sysfail_out, rows[i].sf);
		end
		$display("row table done");
		for (int m = 0; m < 2; m++) begin
			acc(1'b1, SC, m ? 16'h0c00 : 16'h0800, 1'b0);
			for (int v = 0; v < 2; v++) begin
				@(posedge clk);
				{ecl_line0_in, front_panel_trigger_input} <= {v[0], !v[0]};
				cyc(3);
				chk1(ecl_line0_oe_n, !m[0]);
				chk1(m ? ecl_line0_out : front_panel_trigger_output, m[0] ^ v[0]);
			end
		end
		$display("trigger routing done");
		foreach (xf[i]) begin
			@(posedge clk);
			{p_berr, p_par, p_dly, p_go} <= {xf[i][5:0], 1'b1};
			@(posedge clk);
			p_go <= 1'b0;
			cyc(20);
			if (xf[i][6]) begin
				@(posedge clk);
				soft_reset <= 1'b1;
				@(posedge clk);
				soft_reset <= 1'b0;
			end
			rd(SC, 1'b0, xf[i][6] ? 16'h3000 : {13'h0600, xf[i][5], 1'b0, xf[i][4]});
		end
		$display("transfer flags done");
		@(posedge clk);
		controller_switch <= 1'b1;
		// Bit 0 of k picks the long range, bit 1 the jumper end
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, SC, k[0] ? 16'h0008 : 16'h0000, 1'b0);
			lim = k[0] ? (k[1] ? 80 : 40) : (k[1] ? 20 : 10);
			@(posedge clk);
			{p_go, p_hold, p_berr, p_dly} <= 7'h70;
			timeout_jumper_long <= k[1];
			@(posedge clk);
			p_go <= 1'b0;
			n = 0;
			while (controller_timeout_berr !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
			end
			if (n >= 200) begin
				miscompares++;
				final_report();
			end
			chk1(n >= lim && n <= lim + 6, 1'b1);
			@(posedge clk);
			p_hold <= 1'b0;
			cyc(4);
			rd(SC, 1'b0, k[0] ? 16'h388c : 16'h3884);
			rd(SC, 1'b0, k[0] ? 16'h308c : 16'h3084);
		end
		$display("controller timeout done");
		acc(1'b1, SC, 16'h0100, 1'b0);
		n = 0;
		repeat (PULSE + 10) begin
			@(negedge clk);
			n += int'(sysreset_out === 1'b1);
		end
		chk1(n >= PULSE, 1'b1);
		chk1(sysreset_out, 1'b0);
		acc(1'b1, SC, 16'h0004, 1'b0);
		chk1(deadlock_flag_clear, 1'b1);
		cyc(1);
		chk1(deadlock_flag_clear, 1'b0);
		$display("reset pulse and deadlock clear done");
		acc(1'b1, LK, 16'h0001, 1'b0);
		cyc(4);
		chk1(link_lock_hold, 1'b0);
		@(posedge clk);
		link_won <= 1'b1;
		cyc(4);
		chk1(link_lock_hold, 1'b1);
		rd(LK, 1'b0, 16'hffff);
		rd(LK, 1'b1, 16'hfffe);
		acc(1'b1, LK, 16'h0001, 1'b1);
		cyc(2);
		chk1(local_bus_lock, 1'b1);
		rd(LK, 1'b1, 16'hffff);
		acc(1'b1, SC, 16'h0200, 1'b0);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		cyc(3);
		chk1(link_lock_hold | local_bus_lock, 1'b0);
		chk1(sysfail_out, 1'b0);
		rd(LK, 1'b0, 16'hfffe);
		$display("lock done");
		// Line 0 driven and sources routed, so the hard reset has something to undo
		acc(1'b1, SC, 16'h0c78, 1'b0);
		@(posedge clk);
		{trigger_interrupt, sysreset_active, acfail_active} <= 3'h7;
		cyc(2);
		chk1(link_irq_out, 1'b1);
		chk1(ecl_line0_oe_n, 1'b0);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		chk16(reg_rdata, 16'h0000);
		chk1(ecl_line0_oe_n, 1'b1);
		rd(SC, 1'b0, 16'h3080);
		chk1(link_irq_out, 1'b0);
		chk1(front_panel_trigger_output, 1'b0);
		rd(8'h40, 1'b0, 16'h0000);
		$display("hard reset done");
		final_report();
	end
endmodule : tb

`default_nettype wire
